// ===== design/flash_status_pkg.sv
// package: register map, field positions and reset values of the flash status block
package flash_status_pkg;
    localparam logic [7:0] status_offset = 8'h00;
    localparam logic [7:0] config_offset = 8'h04;
    localparam logic [7:0] irq_status_offset = 8'h08;
    localparam logic [7:0] irq_mask_offset = 8'h0C;
    localparam logic [7:0] param_offset = 8'h10;
    localparam int done_bit = 7;
    localparam int collision_bit = 6;
    localparam int access_bit = 5;
    localparam int protect_bit = 4;
    localparam int error_bit = 0;
    localparam int done_ie_bit = 7;
    localparam int collision_ie_bit = 6;
    localparam int irq_done_bit = 0;
    localparam int irq_collision_bit = 1;
    localparam logic [1:0] irq_mask_reset = 2'h0;
    localparam logic [7:0] config_reset = 8'h00;
    localparam logic [7:0] param_reset = 8'h00;
    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic [2:0] hsize_word = 3'h2;
    localparam logic [1:0] hresp_okay = 2'h0;
    localparam int init_cycles = 16;
endpackage

// ===== design/flash_init_seq.sv
// module: reset initialization sequence timer of the flash controller
`timescale 1ns/1ps
module flash_init_seq #(
    parameter int cycles = flash_status_pkg::init_cycles
) (
    input wire logic hclk,
    input wire logic hresetn,
    output logic init_done
);
    logic [15:0] count_reg;

    // counts from reset release, then holds done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= 16'h0000;
            init_done <= 1'b0;
        end else if (!init_done) begin
            if (count_reg == 16'(cycles - 1)) begin
                init_done <= 1'b1;
            end
            count_reg <= count_reg + 16'h0001;
        end
    end
endmodule // flash_init_seq

// ===== design/flash_command_status.sv
// module: flash command status register block with ahb-lite slave
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module flash_command_status #(
    parameter int init_cycles = flash_status_pkg::init_cycles
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic cmd_launch,
    output logic [7:0] cmd_param,
    input wire logic cmd_finish,
    input wire logic cmd_violation,
    input wire logic cmd_fail,
    input wire logic init_fail,
    input wire logic read_collision,
    input wire logic access_violation,
    input wire logic protect_violation,
    output logic irq
);
    logic init_done;
    logic init_done_d_reg;
    logic cmd_done_flag;
    logic read_collision_flag;
    logic access_error_flag;
    logic protect_violation_flag;
    logic cmd_error_status;
    logic [7:0] flash_config_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_mask_reg;
    logic [7:0] param_reg;
    logic ph_write_reg;
    logic ph_read_reg;
    logic [7:0] ph_addr_reg;
    logic addr_valid;
    logic wr_status;
    logic wr_config;
    logic wr_mask;
    logic wr_param;
    logic rd_irq_status;
    logic launch_ok;
    logic done_rise;
    logic [7:0] flash_status_reg;
    logic collision_event;

    // write-one hit on one status bit during a status write data phase
    function automatic logic one_written(input logic strobe, input logic [31:0] data,
        input int pos);
        return strobe && data[pos];
    endfunction

    flash_init_seq #(
        .cycles(init_cycles)
    ) u_init (
        .hclk(hclk),
        .hresetn(hresetn),
        .init_done(init_done)
    );

    // address phase capture for a single nonseq transfer of any size; hsize is not decoded
    assign addr_valid = hsel && hready && (htrans == flash_status_pkg::htrans_nonseq);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_write_reg <= 1'b0;
            ph_read_reg <= 1'b0;
            ph_addr_reg <= 8'h00;
        end else if (hready) begin
            ph_write_reg <= addr_valid && hwrite;
            ph_read_reg <= addr_valid && !hwrite;
            ph_addr_reg <= haddr[7:0];
        end
    end

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = flash_status_pkg::hresp_okay;

    // data phase write strobes and the irq status read strobe
    assign wr_status = ph_write_reg && (ph_addr_reg == flash_status_pkg::status_offset);
    assign wr_config = ph_write_reg && (ph_addr_reg == flash_status_pkg::config_offset);
    assign wr_mask = ph_write_reg && (ph_addr_reg == flash_status_pkg::irq_mask_offset);
    assign wr_param = ph_write_reg && (ph_addr_reg == flash_status_pkg::param_offset);
    assign rd_irq_status = ph_read_reg && (ph_addr_reg == flash_status_pkg::irq_status_offset);

    // launch needs a one on done bit, done set, access and protect error flags clear
    assign launch_ok = wr_status && hwdata[flash_status_pkg::done_bit]
        && cmd_done_flag
        && !access_error_flag && !protect_violation_flag
        && !hwdata[flash_status_pkg::access_bit] && !hwdata[flash_status_pkg::protect_bit];
    assign cmd_launch = launch_ok;

    // done flag; init end also raises it the first time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_done_flag <= 1'b0;
            init_done_d_reg <= 1'b0;
        end else begin
            init_done_d_reg <= init_done;
            if (init_done && !init_done_d_reg) begin
                cmd_done_flag <= 1'b1;
            end else if (launch_ok) begin
                cmd_done_flag <= 1'b0;
            end else if (done_rise) begin
                cmd_done_flag <= 1'b1;
            end
        end
    end

    // sticky w1c error flags; a new event beats a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_collision_flag <= 1'b0;
            access_error_flag <= 1'b0;
            protect_violation_flag <= 1'b0;
        end else begin
            if (collision_event) begin
                read_collision_flag <= 1'b1;
            end else if (one_written(wr_status, hwdata, flash_status_pkg::collision_bit)) begin
                read_collision_flag <= 1'b0;
            end
            if (access_violation) begin
                access_error_flag <= 1'b1;
            end else if (one_written(wr_status, hwdata, flash_status_pkg::access_bit)) begin
                access_error_flag <= 1'b0;
            end
            if (protect_violation) begin
                protect_violation_flag <= 1'b1;
            end else if (one_written(wr_status, hwdata, flash_status_pkg::protect_bit)) begin
                protect_violation_flag <= 1'b0;
            end
        end
    end

    // command error result, hardware only, dropped at next launch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_error_status <= 1'b0;
        end else if (init_fail || (cmd_fail && !cmd_done_flag)) begin
            cmd_error_status <= 1'b1;
        end else if (launch_ok) begin
            cmd_error_status <= 1'b0;
        end
    end

    // config register stays writable while a command runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_config_reg <= flash_status_pkg::config_reset;
        end else if (wr_config) begin
            flash_config_reg <= {hwdata[7:6], 6'h00};
        end
    end

    // parameter register locked while running; free before init ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            param_reg <= flash_status_pkg::param_reset;
        end else if (wr_param && (cmd_done_flag || !init_done_d_reg)) begin
            param_reg <= hwdata[7:0];
        end
    end
    assign cmd_param = param_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_reg <= flash_status_pkg::irq_mask_reset;
        end else if (wr_mask) begin
            irq_mask_reg <= hwdata[1:0];
        end
    end

    // sticky interrupt events, cleared by a read; an event beats the clear
    assign done_rise = !cmd_done_flag && init_done_d_reg && (cmd_finish || cmd_violation);
    // a collision counts while a command holds the array, and also before init ends (done flag still low)
    assign collision_event = read_collision && !cmd_done_flag;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_reg <= 2'h0;
        end else begin
            irq_status_reg[flash_status_pkg::irq_done_bit] <= done_rise
                || (irq_status_reg[flash_status_pkg::irq_done_bit] && !rd_irq_status);
            irq_status_reg[flash_status_pkg::irq_collision_bit] <=
                collision_event
                || (irq_status_reg[flash_status_pkg::irq_collision_bit] && !rd_irq_status);
        end
    end

    // done request is a level while flag is set; collision from sticky bit
    assign irq = (flash_config_reg[flash_status_pkg::done_ie_bit] && cmd_done_flag)
        || (flash_config_reg[flash_status_pkg::collision_ie_bit]
            && irq_status_reg[flash_status_pkg::irq_collision_bit])
        || |(irq_status_reg & irq_mask_reg);

    // reserved bits tie low, error status only driven by hardware
    assign flash_status_reg = {cmd_done_flag, read_collision_flag, access_error_flag,
        protect_violation_flag, 3'h0, cmd_error_status};

    // registered read data, launched in address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_valid && !hwrite) begin
            unique case (haddr[7:0])
                flash_status_pkg::status_offset: hrdata <= {24'h000000, flash_status_reg};
                flash_status_pkg::config_offset: hrdata <= {24'h000000, flash_config_reg};
                flash_status_pkg::irq_status_offset: hrdata <= {30'h00000000, irq_status_reg};
                flash_status_pkg::irq_mask_offset: hrdata <= {30'h00000000, irq_mask_reg};
                flash_status_pkg::param_offset: hrdata <= {24'h000000, param_reg};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end
endmodule // flash_command_status

// ===== tb/flash_command_status_properties.sv
// checker: port-level properties of the flash status block
`timescale 1ns/1ps
module flash_command_status_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    input wire logic cmd_launch,
    input wire logic cmd_finish,
    input wire logic cmd_violation
);
    logic wr_ph, rd_ph, st_ph, busy_h, fin_h, take;
    assign take = hsel && hready && htrans == flash_status_pkg::htrans_nonseq;
    // data phase flags, one cycle behind the accepted address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph <= 1'b0;
            rd_ph <= 1'b0;
            st_ph <= 1'b0;
        end else if (hready) begin
            wr_ph <= take && hwrite;
            rd_ph <= take && !hwrite;
            st_ph <= haddr[7:0] == flash_status_pkg::status_offset;
        end
    end
    // shadow of a running command; ends on finish or violation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_h <= 1'b0;
            fin_h <= 1'b0;
        end else if (cmd_launch) begin
            busy_h <= 1'b1;
        end else if (cmd_finish || cmd_violation) begin
            busy_h <= 1'b0;
            fin_h <= 1'b1;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_launch_cause: assert property (cmd_launch |-> wr_ph && st_ph && hwdata[7])
        else $error("launch without a status write of bit 7");
    a_launch_idle: assert property (cmd_launch |-> !busy_h)
        else $error("launch while a command runs");
    a_launch_single: assert property (cmd_launch |=> !cmd_launch)
        else $error("launch pulse longer than one cycle");
    a_busy_reads_low: assert property (rd_ph && st_ph && busy_h && $past(busy_h) |-> !hrdata[7])
        else $error("done flag read high while running");
    a_done_after_end: assert property (rd_ph && st_ph && fin_h && !busy_h && !$past(busy_h)
        |-> hrdata[7])
        else $error("done flag low after command end");
    a_reserved_zero: assert property (rd_ph && st_ph |-> hrdata[3:1] == 3'h0)
        else $error("reserved status bits not zero");
    a_upper_zero: assert property (rd_ph && st_ph |-> hrdata[31:8] == 24'h0)
        else $error("status upper bits not zero");
    a_ready_okay: assert property (hreadyout && hresp == flash_status_pkg::hresp_okay)
        else $error("slave not ready or not okay");
endmodule // flash_command_status_properties

bind flash_command_status flash_command_status_properties u_props (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cmd_launch(cmd_launch), .cmd_finish(cmd_finish), .cmd_violation(cmd_violation));

// ===== tb/flash_command_status_test.sv
// testbench: ahb-lite driven checks of the flash status block
`timescale 1ns/1ps
module flash_command_status_test;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout;
    logic cmd_launch, irq;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0, hresp;
    logic [2:0] hsize = flash_status_pkg::hsize_word;
    logic [6:0] ev = 7'h00;
    logic [7:0] cmd_param, p, b;
    int miscompares = 0, check_count = 0, launches = 0, exp_l = 0;
    assign hready = hreadyout;
    initial forever #2.5 hclk = ~hclk;
    always @(posedge hclk) if (cmd_launch === 1'b1) launches++;
    flash_command_status #(.init_cycles(4)) u_flash_command_status (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cmd_launch(cmd_launch), .cmd_param(cmd_param),
        .cmd_finish(ev[0]), .cmd_violation(ev[1]), .cmd_fail(ev[2]), .init_fail(ev[3]),
        .read_collision(ev[4]), .access_violation(ev[5]), .protect_violation(ev[6]), .irq(irq));
    task print_verdict;
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // expected status flag raised by engine event i (5 access, 6 protect)
    function automatic logic [7:0] flag_of(input int i);
        return 8'h01 << ((i == 5) ? flash_status_pkg::access_bit
            : flash_status_pkg::protect_bit);
    endfunction
    // bounded wait; the slave should never stall
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            miscompares++;
            print_verdict;
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= flash_status_pkg::htrans_nonseq;
        hwrite <= w;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
    endtask
    task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 32'h0);
        check(n, r, {24'h0, e});
    endtask
    // engine event pulse of one cycle, then an idle edge so pulses never merge
    task pulse(input int i);
        ev <= 7'h01 << i;
        @(posedge hclk);
        ev <= 7'h00;
        @(posedge hclk);
    endtask
    // let the edge's register updates land before sampling irq
    task ichk(input logic e);
        @(posedge hclk);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask
    initial begin
        r = $urandom(32'h00C5);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        // parameter write right after release, before the first completion
        p = 8'($urandom);
        xfer(1'b1, 8'h10, {24'h0, p});
        repeat (10) @(posedge hclk);
        rchk("init done", 8'h00, 8'h80);
        rchk("param init", 8'h10, p);
        xfer(1'b1, 8'h0C, 32'h1);
        xfer(1'b0, 8'h08, 32'h0);
        xfer(1'b1, 8'h04, 32'h80);
        ichk(1'b1);
        p = 8'($urandom);
        xfer(1'b1, 8'h10, {24'h0, p});
        xfer(1'b1, 8'h00, 32'h80);
        exp_l++;
        rchk("busy", 8'h00, 8'h00);
        check("launches", launches, exp_l);
        ichk(1'b0);
        xfer(1'b1, 8'h10, {24'h0, ~p});
        rchk("param busy", 8'h10, p);
        pulse(4);
        xfer(1'b1, 8'h00, 32'h80);
        rchk("collision", 8'h00, 8'h40);
        check("launches", launches, exp_l);
        ichk(1'b0);
        xfer(1'b1, 8'h04, 32'hC0);
        ichk(1'b1);
        xfer(1'b1, 8'h00, 32'h0);
        rchk("collision kept", 8'h00, 8'h40);
        xfer(1'b1, 8'h00, 32'h40);
        rchk("collision clr", 8'h00, 8'h00);
        pulse(2);
        pulse(0);
        rchk("fail end", 8'h00, 8'h81);
        xfer(1'b1, 8'h00, 32'h01);
        rchk("error ro", 8'h00, 8'h81);
        rchk("irq events", 8'h08, 8'h03);
        rchk("irq clr", 8'h08, 8'h00);
        xfer(1'b1, 8'h04, 32'h0);
        xfer(1'b1, 8'h00, 32'h80);
        exp_l++;
        rchk("error cleared", 8'h00, 8'h00);
        pulse(0);
        ichk(1'b1);
        rchk("done event", 8'h08, 8'h01);
        ichk(1'b0);
        xfer(1'b1, 8'h00, 32'h80);
        exp_l++;
        pulse(1);
        rchk("violation end", 8'h00, 8'h80);
        // both error flags: set, block launch, survive a zero write, clear
        for (int i = 5; i < 7; i++) begin
            b = flag_of(i);
            pulse(i);
            rchk("err set", 8'h00, 8'h80 | b);
            xfer(1'b1, 8'h00, 32'h80);
            rchk("err blocks", 8'h00, 8'h80 | b);
            xfer(1'b1, 8'h00, 32'h0);
            rchk("err kept", 8'h00, 8'h80 | b);
            xfer(1'b1, 8'h00, {24'h0, 8'h80 | b});
            rchk("err clr", 8'h00, 8'h80);
        end
        check("launches", launches, exp_l);
        xfer(1'b1, 8'h00, 32'h0E);
        rchk("reserved", 8'h00, 8'h80);
        xfer(1'b1, 8'h20, 32'hFF);
        rchk("unmapped", 8'h20, 8'h00);
        pulse(3);
        rchk("init fail", 8'h00, 8'h81);
        repeat (4) begin
            p = 8'($urandom);
            xfer(1'b1, 8'h10, {24'h0, p});
            rchk("param idle", 8'h10, p);
            check("param out", {24'h0, cmd_param}, {24'h0, p});
        end
        print_verdict;
    end
endmodule // flash_command_status_test
